/* File: hw/pbcmux_pkg.sv */
// Package for the port B / port C pin-function multiplexer.
// Assumes a single 125 MHz clock and a plain register port with
// one-cycle read latency.
package pbcmux_pkg;

   // ----------------------------------------------------------------
   // Register map, word indexes on the plain register port
   // ----------------------------------------------------------------
   localparam logic [2:0]  PBCMUX_IDX_PB_CTRL   = 3'h0;
   localparam logic [2:0]  PBCMUX_IDX_PC_DIR    = 3'h1;
   localparam logic [2:0]  PBCMUX_IDX_PC_UPPER  = 3'h2;
   localparam logic [2:0]  PBCMUX_IDX_PC_LOWER  = 3'h3;

   // ----------------------------------------------------------------
   // Reset values, writable masks and reserved bits that read as one
   // ----------------------------------------------------------------
   localparam logic [15:0] PBCMUX_RST_PB_CTRL   = 16'h00c0;
   localparam logic [15:0] PBCMUX_WR_PB_CTRL    = 16'h1f3f;
   localparam logic [15:0] PBCMUX_ONE_PB_CTRL   = 16'h00c0;
   localparam logic [15:0] PBCMUX_RST_PC_DIR    = 16'h8000;
   localparam logic [15:0] PBCMUX_WR_PC_DIR     = 16'h7fff;
   localparam logic [15:0] PBCMUX_ONE_PC_DIR    = 16'h8000;
   localparam logic [15:0] PBCMUX_RST_PC_UPPER  = 16'hc000;
   localparam logic [15:0] PBCMUX_WR_PC_UPPER   = 16'h3fff;
   localparam logic [15:0] PBCMUX_ONE_PC_UPPER  = 16'hc000;
   localparam logic [15:0] PBCMUX_RST_PC_LOWER  = 16'h0bff;
   localparam logic [15:0] PBCMUX_WR_PC_LOWER   = 16'hf555;
   localparam logic [15:0] PBCMUX_ONE_PC_LOWER  = 16'h0aaa;

   // ----------------------------------------------------------------
   // Field positions in the lower port C register and the port B control register
   // ----------------------------------------------------------------
   localparam int PBCMUX_POS_PC7   = 14;
   localparam int PBCMUX_POS_PC6   = 12;
   localparam int PBCMUX_POS_PC5   = 10;
   localparam int PBCMUX_POS_PC4   = 8;
   localparam int PBCMUX_POS_PC3   = 6;
   localparam int PBCMUX_POS_PC2   = 4;
   localparam int PBCMUX_POS_PC1   = 2;
   localparam int PBCMUX_POS_PC0   = 0;
   localparam int PBCMUX_POS_PB6   = 8;

   // Pin counts.
   localparam int PBCMUX_PB_PINS   = 11;
   localparam int PBCMUX_PC_PINS   = 15;

   // Operating mode straps.
   typedef enum logic [1:0] {
      PBCMUX_MODE_EXP_NOROM = 2'h0,
      PBCMUX_MODE_EXP_ROM   = 2'h1,
      PBCMUX_MODE_SINGLE    = 2'h2
   } pbcmux_mode_type;

   // Two-bit function codes.
   localparam logic [1:0]  PBCMUX_FN_GPIO  = 2'h0;
   localparam logic [1:0]  PBCMUX_FN_ALT1  = 2'h1;
   localparam logic [1:0]  PBCMUX_FN_ALT2  = 2'h2;
   localparam logic [1:0]  PBCMUX_FN_ALT3  = 2'h3;

   // Register port request.
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [2:0]  addr;
      logic [15:0] wdata;
   } pbcmux_req_type;

endpackage

/* File: hw/pbcmux_top.sv */
// Pin-function multiplexer for port B pins 10..0 and port C pins 14..0.
// Assumes the operating mode straps are stable while running and that
// peripheral signals are on clk_i; pin inputs arrive asynchronously.
`timescale 1ns/10ps
`default_nettype none

module pbcmux_top (
   // Clock and reset.
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   // Operating mode straps.
   input  wire pbcmux_pkg::pbcmux_mode_type mode_i,
   // Register port.
   input  wire pbcmux_pkg::pbcmux_req_type  req_i,
   output logic [15:0]                 rdata_o,
   // Port B pins.
   input  wire logic [10:0]            portb_pin_in_i,
   output logic [10:0]                 portb_pin_out_o,
   output logic [10:0]                 portb_pin_oe_o,
   // Port C pins.
   input  wire logic [14:0]            portc_pin_in_i,
   output logic [14:0]                 portc_pin_out_o,
   output logic [14:0]                 portc_pin_oe_o,
   // General I/O data and port B direction from the port data logic.
   input  wire logic [10:0]            portb_gpio_data_i,
   input  wire logic [10:0]            portb_gpio_dir_i,
   input  wire logic [14:0]            portc_gpio_data_i,
   output logic [10:0]                 portb_gpio_in_o,
   output logic [14:0]                 portc_gpio_in_o,
   // Peripheral outputs routed to pins.
   input  wire logic [4:0]             address_hi_i,
   input  wire logic [3:0]             timer_pwm_out_i,
   input  wire logic [7:0]             oneshot_out_i,
   input  wire logic [1:0]             dma_accept_i,
   input  wire logic [2:0]             chip_select_n_i,
   input  wire logic                   read_strobe_n_i,
   input  wire logic                   high_byte_write_strobe_n_i,
   input  wire logic                   low_byte_write_strobe_n_i,
   input  wire logic                   conversion_done_out_i,
   // Pin inputs routed to peripherals.
   output logic                        timer_ext_clock_a_o,
   output logic                        timer_ext_clock_b_o,
   output logic                        bus_wait_n_o,
   output logic                        external_interrupt_six_o
);

   // ----------------------------------------------------------------
   // Registers and helpers
   // ----------------------------------------------------------------
   logic [15:0] pb_ctrl;
   logic [15:0] pc_dir;
   logic [15:0] pc_upper;
   logic [15:0] pc_lower;
   logic [25:0] sync1;
   logic [25:0] sync2;
   logic [25:0] sync3;
   logic [25:0] pin_in;
   logic [10:0] next_pb_out;
   logic [10:0] next_pb_oe;
   logic [14:0] next_pc_out;
   logic [14:0] next_pc_oe;
   logic [14:0] pc_alt;
   logic        expanded;

   // Stored value after a write: only writable bits change, reserved stay one.
   function automatic logic [15:0] merge(input logic [15:0] wdata,
                                         input logic [15:0] wmask,
                                         input logic [15:0] ones);
      merge = (wdata & wmask) | ones;
   endfunction

   // Two-bit function field of port C pins 7 to 14, pins 8 and up in the upper register.
   function automatic logic [1:0] pc_field(input logic [15:0] upper,
                                           input logic [15:0] lower,
                                           input int          pin);
      if (pin >= 8) begin
         pc_field = upper[2*(pin-8) +: 2];
      end else begin
         pc_field = lower[pbcmux_pkg::PBCMUX_POS_PC7 +: 2];
      end
   endfunction

   assign expanded = (mode_i == pbcmux_pkg::PBCMUX_MODE_EXP_NOROM) ||
                     (mode_i == pbcmux_pkg::PBCMUX_MODE_EXP_ROM);

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   // Writes keep reserved bits at one whatever software sends.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pb_ctrl  <= pbcmux_pkg::PBCMUX_RST_PB_CTRL;
         pc_dir   <= pbcmux_pkg::PBCMUX_RST_PC_DIR;
         pc_upper <= pbcmux_pkg::PBCMUX_RST_PC_UPPER;
         pc_lower <= pbcmux_pkg::PBCMUX_RST_PC_LOWER;
      end else if (req_i.wr) begin
         unique case (req_i.addr)
            pbcmux_pkg::PBCMUX_IDX_PB_CTRL: begin
               pb_ctrl <= merge(req_i.wdata, pbcmux_pkg::PBCMUX_WR_PB_CTRL,
                                pbcmux_pkg::PBCMUX_ONE_PB_CTRL);
            end
            pbcmux_pkg::PBCMUX_IDX_PC_DIR: begin
               pc_dir <= merge(req_i.wdata, pbcmux_pkg::PBCMUX_WR_PC_DIR,
                               pbcmux_pkg::PBCMUX_ONE_PC_DIR);
            end
            pbcmux_pkg::PBCMUX_IDX_PC_UPPER: begin
               pc_upper <= merge(req_i.wdata, pbcmux_pkg::PBCMUX_WR_PC_UPPER,
                                 pbcmux_pkg::PBCMUX_ONE_PC_UPPER);
            end
            pbcmux_pkg::PBCMUX_IDX_PC_LOWER: begin
               pc_lower <= merge(req_i.wdata, pbcmux_pkg::PBCMUX_WR_PC_LOWER,
                                 pbcmux_pkg::PBCMUX_ONE_PC_LOWER);
            end
            default: begin
            end
         endcase
      end
   end

   // Read data stands for exactly one cycle; unmapped indexes read zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= 16'h0000;
      end else if (req_i.rd) begin
         unique case (req_i.addr)
            pbcmux_pkg::PBCMUX_IDX_PB_CTRL:  rdata_o <= pb_ctrl;
            pbcmux_pkg::PBCMUX_IDX_PC_DIR:   rdata_o <= pc_dir;
            pbcmux_pkg::PBCMUX_IDX_PC_UPPER: rdata_o <= pc_upper;
            pbcmux_pkg::PBCMUX_IDX_PC_LOWER: rdata_o <= pc_lower;
            default:                         rdata_o <= 16'h0000;
         endcase
      end else begin
         rdata_o <= 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // Pin input synchroniser
   // ----------------------------------------------------------------
   // A change is taken only when the second and third stages agree, which
   // filters a one-cycle glitch at the cost of one extra cycle of latency.
   // The stages start at the released-pad level; starting at zero would show
   // a wait request on the bus for several cycles after every reset.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1  <= '1;
         sync2  <= '1;
         sync3  <= '1;
         pin_in <= '1;
      end else begin
         sync1  <= {portc_pin_in_i, portb_pin_in_i};
         sync2  <= sync1;
         sync3  <= sync2;
         pin_in <= (sync2 & ~(sync2 ^ sync3)) |
                   (pin_in & (sync2 ^ sync3));
      end
   end

   // ----------------------------------------------------------------
   // Function selection and pin drive
   // ----------------------------------------------------------------
   // Port B: address lines, timer PWM outputs, timer clock inputs, else general I/O.
   always_comb begin
      next_pb_out = portb_gpio_data_i;
      next_pb_oe  = portb_gpio_dir_i;
      for (int i = 6; i <= 10; i++) begin
         if ((mode_i == pbcmux_pkg::PBCMUX_MODE_EXP_NOROM) ||
             ((mode_i == pbcmux_pkg::PBCMUX_MODE_EXP_ROM) &&
              pb_ctrl[pbcmux_pkg::PBCMUX_POS_PB6 + i - 6])) begin
            next_pb_out[i] = address_hi_i[i-6];
            next_pb_oe[i]  = 1'b1;
         end
      end
      for (int i = 0; i <= 3; i++) begin
         if (pb_ctrl[i]) begin
            next_pb_out[i] = timer_pwm_out_i[i];
            next_pb_oe[i]  = 1'b1;
         end
      end
      // Timer clock pins are inputs only; the data register is ignored.
      for (int i = 4; i <= 5; i++) begin
         if (pb_ctrl[i]) begin
            next_pb_out[i] = 1'b0;
            next_pb_oe[i]  = 1'b0;
         end
      end
   end

   // Port C: direction register applies only where the pin is general I/O.
   always_comb begin
      logic [1:0] fn;
      fn          = pbcmux_pkg::PBCMUX_FN_GPIO;
      pc_alt      = '0;
      next_pc_out = portc_gpio_data_i;
      next_pc_oe  = pc_dir[14:0];
      // One-shot and DMA accept pins; reserved codes stay general I/O.
      for (int p = 7; p <= 14; p++) begin
         fn = pc_field(pc_upper, pc_lower, p);
         if (fn == pbcmux_pkg::PBCMUX_FN_ALT1) begin
            pc_alt[p]      = 1'b1;
            next_pc_out[p] = oneshot_out_i[p-7];
         end else if ((fn == pbcmux_pkg::PBCMUX_FN_ALT2) &&
                      ((p == 12) || (p == 11))) begin
            pc_alt[p]      = 1'b1;
            next_pc_out[p] = dma_accept_i[p-11];
         end
      end
      // PC6: chip select only when expanded, interrupt and done in any mode.
      fn = pc_lower[pbcmux_pkg::PBCMUX_POS_PC6 +: 2];
      if ((fn == pbcmux_pkg::PBCMUX_FN_ALT1) && expanded) begin
         pc_alt[6]      = 1'b1;
         next_pc_out[6] = chip_select_n_i[2];
      end else if (fn == pbcmux_pkg::PBCMUX_FN_ALT2) begin
         pc_alt[6]      = 1'b1;
         next_pc_out[6] = 1'b0;
      end else if (fn == pbcmux_pkg::PBCMUX_FN_ALT3) begin
         pc_alt[6]      = 1'b1;
         next_pc_out[6] = conversion_done_out_i;
      end
      // Single-bit bus pins take effect only in expanded mode.
      if (expanded) begin
         pc_alt[5] = pc_lower[pbcmux_pkg::PBCMUX_POS_PC5];
         pc_alt[4] = pc_lower[pbcmux_pkg::PBCMUX_POS_PC4];
         pc_alt[3] = pc_lower[pbcmux_pkg::PBCMUX_POS_PC3];
         pc_alt[2] = pc_lower[pbcmux_pkg::PBCMUX_POS_PC2];
         pc_alt[1] = pc_lower[pbcmux_pkg::PBCMUX_POS_PC1];
         pc_alt[0] = pc_lower[pbcmux_pkg::PBCMUX_POS_PC0];
      end
      if (pc_alt[5]) next_pc_out[5] = chip_select_n_i[1];
      if (pc_alt[4]) next_pc_out[4] = chip_select_n_i[0];
      if (pc_alt[3]) next_pc_out[3] = read_strobe_n_i;
      if (pc_alt[2]) next_pc_out[2] = 1'b0;
      if (pc_alt[1]) next_pc_out[1] = high_byte_write_strobe_n_i;
      if (pc_alt[0]) next_pc_out[0] = low_byte_write_strobe_n_i;
      // Alternate functions own the enable; interrupt and wait are inputs.
      for (int p = 0; p < pbcmux_pkg::PBCMUX_PC_PINS; p++) begin
         if (pc_alt[p]) begin
            next_pc_oe[p] = 1'b1;
         end
      end
      if (pc_alt[2]) next_pc_oe[2] = 1'b0;
      if (pc_alt[6] && (fn == pbcmux_pkg::PBCMUX_FN_ALT2)) next_pc_oe[6] = 1'b0;
   end

   // Pin drive comes from flip-flops so a select change never glitches a pin.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         portb_pin_out_o <= '0;
         portb_pin_oe_o  <= '0;
         portc_pin_out_o <= '0;
         portc_pin_oe_o  <= '0;
      end else begin
         portb_pin_out_o <= next_pb_out;
         portb_pin_oe_o  <= next_pb_oe;
         portc_pin_out_o <= next_pc_out;
         portc_pin_oe_o  <= next_pc_oe;
      end
   end

   // Inputs handed to peripherals sit idle when the pin is not theirs.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_ext_clock_a_o      <= 1'b0;
         timer_ext_clock_b_o      <= 1'b0;
         bus_wait_n_o             <= 1'b1;
         external_interrupt_six_o <= 1'b0;
         portb_gpio_in_o          <= '0;
         portc_gpio_in_o          <= '0;
      end else begin
         timer_ext_clock_a_o      <= pb_ctrl[4] & pin_in[4];
         timer_ext_clock_b_o      <= pb_ctrl[5] & pin_in[5];
         bus_wait_n_o             <= pc_alt[2] ? pin_in[13] : 1'b1;
         external_interrupt_six_o <= (pc_lower[pbcmux_pkg::PBCMUX_POS_PC6 +: 2] ==
                                      pbcmux_pkg::PBCMUX_FN_ALT2) & pin_in[17];
         portb_gpio_in_o          <= pin_in[10:0];
         portc_gpio_in_o          <= pin_in[25:11];
      end
   end

endmodule // pbcmux_top

`default_nettype wire

/* File: dv/pbcmux_monitor.sv */
// Port checker for the port B / port C pin-function multiplexer.
// Assumes it is bound into pbcmux_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none

module pbcmux_monitor (
   // Clock and reset.
   input wire logic                        clk_i,
   input wire logic                        rst_i,
   // Mode straps and register port.
   input wire pbcmux_pkg::pbcmux_mode_type mode_i,
   input wire pbcmux_pkg::pbcmux_req_type  req_i,
   input wire logic [15:0]                 rdata_o,
   // Pins and the values routed to them.
   input wire logic [10:0]                 portb_pin_out_o,
   input wire logic [10:0]                 portb_pin_oe_o,
   input wire logic [10:0]                 portb_gpio_data_i,
   input wire logic [10:0]                 portb_gpio_dir_i,
   input wire logic [14:0]                 portc_pin_out_o,
   input wire logic [14:0]                 portc_pin_oe_o,
   input wire logic [14:0]                 portc_gpio_data_i,
   input wire logic [4:0]                  address_hi_i,
   input wire logic                        bus_wait_n_o
);
   // -------------------------------------------------------------
   // Port relations
   // -------------------------------------------------------------
   // One clock domain; reset silences every check.
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_rdata_idle_zero: assert property (rdata_o != 16'h0 |-> $past(req_i.rd))
      else $error("read data seen without a preceding read");
   a_lower_reserved_ones: assert property ($past(req_i.rd) && $past(req_i.addr) == 3'h3
      |-> (rdata_o & 16'h0aaa) == 16'h0aaa) else $error("reserved bit read as zero");
   a_dir_write_readback: assert property (req_i.wr && req_i.addr == 3'h1
      ##1 req_i.rd && req_i.addr == 3'h1
      |=> rdata_o == (($past(req_i.wdata, 2) & 16'h7fff) | 16'h8000))
      else $error("direction readback wrong");
   a_pb_single_gpio: assert property (!$past(rst_i) && $past(mode_i[1])
      |-> portb_pin_oe_o[10:6] == $past(portb_gpio_dir_i[10:6])
      && portb_pin_out_o[10:6] == $past(portb_gpio_data_i[10:6]))
      else $error("address pins not general I/O in single-chip mode");
   a_pb_norom_address: assert property (!$past(rst_i) && $past(mode_i) == 2'h0
      |-> portb_pin_oe_o[10:6] == 5'h1f && portb_pin_out_o[10:6] == $past(address_hi_i))
      else $error("address pins not driving address without ROM");
   a_pb_dir_drive: assert property (!$past(rst_i)
      |-> (~portb_pin_oe_o & $past(portb_gpio_dir_i) & 11'h7cf) == 11'h0)
      else $error("output pin released while direction asks to drive");
   a_pc_single_data: assert property (!$past(rst_i) && $past(mode_i[1])
      |-> ((portc_pin_out_o ^ $past(portc_gpio_data_i)) & portc_pin_oe_o & 15'h3f) == 15'h0)
      else $error("bus control pin not general I/O in single-chip mode");
   a_wait_single_high: assert property (mode_i[1] [*8] |=> bus_wait_n_o)
      else $error("wait request seen in single-chip mode");
endmodule // pbcmux_monitor

bind pbcmux_top pbcmux_monitor pbcmux_monitor_i (
   .clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i), .req_i(req_i), .rdata_o(rdata_o),
   .portb_pin_out_o(portb_pin_out_o), .portb_pin_oe_o(portb_pin_oe_o),
   .portb_gpio_data_i(portb_gpio_data_i), .portb_gpio_dir_i(portb_gpio_dir_i),
   .portc_pin_out_o(portc_pin_out_o), .portc_pin_oe_o(portc_pin_oe_o),
   .portc_gpio_data_i(portc_gpio_data_i), .address_hi_i(address_hi_i),
   .bus_wait_n_o(bus_wait_n_o));
`default_nettype wire

/* File: dv/pbcmux_board.sv */
// Board model for the multiplexed pads of ports B and C.
// Assumes pad vectors are concatenated, port C above port B.
`timescale 1ns/10ps
`default_nettype none

module pbcmux_board #(
   parameter int W = 26
) (
   // Device side of the pads.
   input  wire logic [W-1:0] pad_out_i,
   input  wire logic [W-1:0] pad_oe_i,
   // Board sources.
   input  wire logic [W-1:0] drive_i,
   input  wire logic [W-1:0] drive_en_i,
   // Resolved pad level.
   output logic [W-1:0]      level_o
);
   // Board sources yield where the device drives, so contention never hides a fault.
   // Released pads with no source fall to the board pull-up.
   assign level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ((drive_en_i & drive_i) | ~drive_en_i));
endmodule // pbcmux_board
`default_nettype wire

/* File: dv/test_port_b_c_pin_function_mux.sv */
// Self-checking bench for the port B / port C pin-function multiplexer.
// Assumes pbcmux_top, pbcmux_board and the bound checker compile first.
`timescale 1ns/10ps
`default_nettype none

module test_port_b_c_pin_function_mux;
   // -------------------------------------------------------------
   // Stimulus, design and board
   // -------------------------------------------------------------
   logic                        clk = 1'b0;
   logic                        rst = 1'b1;
   pbcmux_pkg::pbcmux_mode_type md;
   pbcmux_pkg::pbcmux_req_type  req;
   logic [15:0]                 rdata;
   logic [25:0]                 lvl, x, xen, eoe, eout, elvl;
   logic [10:0]                 gdat_b, gdir_b, pb_out, pb_oe, gin_b;
   logic [14:0]                 gdat_c, pc_out, pc_oe, gin_c;
   logic [4:0]                  ahi;
   logic [3:0]                  pwm, strb;
   logic [7:0]                  osh;
   logic [1:0]                  dma;
   logic [2:0]                  cs;
   logic                        tca, tcb, wt_n, irq;
   logic [15:0]                 m [4];
   logic [15:0]                 rq [$];
   int                          n_mismatch = 0;
   int                          checked = 0;

   always #4 clk = ~clk;

   pbcmux_top pbcmux_top_i (
      .clk_i(clk), .rst_i(rst), .mode_i(md), .req_i(req), .rdata_o(rdata),
      .portb_pin_in_i(lvl[10:0]), .portb_pin_out_o(pb_out), .portb_pin_oe_o(pb_oe),
      .portc_pin_in_i(lvl[25:11]), .portc_pin_out_o(pc_out), .portc_pin_oe_o(pc_oe),
      .portb_gpio_data_i(gdat_b), .portb_gpio_dir_i(gdir_b), .portc_gpio_data_i(gdat_c),
      .portb_gpio_in_o(gin_b), .portc_gpio_in_o(gin_c), .address_hi_i(ahi),
      .timer_pwm_out_i(pwm), .oneshot_out_i(osh), .dma_accept_i(dma), .chip_select_n_i(cs),
      .read_strobe_n_i(strb[3]), .high_byte_write_strobe_n_i(strb[2]),
      .low_byte_write_strobe_n_i(strb[1]), .conversion_done_out_i(strb[0]),
      .timer_ext_clock_a_o(tca), .timer_ext_clock_b_o(tcb), .bus_wait_n_o(wt_n),
      .external_interrupt_six_o(irq));
   pbcmux_board pbcmux_board_i (.pad_out_i({pc_out, pb_out}), .pad_oe_i({pc_oe, pb_oe}),
      .drive_i(x), .drive_en_i(xen), .level_o(lvl));

   // Counts every comparison and reports a mismatch at once.
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Register writes keep a shadow copy; reserved bits are written as ones except in the port C direction register.
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      req <= '{1'b1, 1'b0, a, d | (a == 3'h0 ? 16'h00c0 : a == 3'h2 ? 16'hc000 :
                                   a == 3'h3 ? 16'h0aaa : 16'h0000)};
      @(posedge clk);
      if (a == 3'h0)
         m[0] = (d & 16'h1f3f) | 16'h00c0;
      if (a == 3'h1)
         m[1] = (d & 16'h7fff) | 16'h8000;
      if (a == 3'h2)
         m[2] = (d & 16'h3fff) | 16'hc000;
      if (a == 3'h3)
         m[3] = (d & 16'hf555) | 16'h0aaa;
   endtask

   // A read queues its expectation; the data is judged in the following cycle.
   task automatic rd(input logic [2:0] a);
      req <= '{1'b0, 1'b1, a, 16'h0};
      @(posedge clk);
      rq.push_back(a < 3'h4 ? m[a[1:0]] : 16'h0);
   endtask

   always @(negedge clk)
      if (rq.size() > 0)
         chk("rdata", 32'(rq.pop_front()), 32'(rdata));

   // Reference pin routing, built from the mode fields and the current inputs.
   task automatic model;
      logic [1:0] c;
      logic [5:0] lo;
      lo = {cs[1], cs[0], strb[3], 1'b0, strb[2], strb[1]};
      for (int i = 0; i < 11; i++) begin
         {eoe[i], eout[i]} = {gdir_b[i], gdat_b[i]};
         if (i < 4 && m[0][i])
            {eoe[i], eout[i]} = {1'b1, pwm[i]};
         if ((i == 4 || i == 5) && m[0][i])
            eoe[i] = 1'b0;
         if (i > 5 && (md == 2'h0 || (md == 2'h1 && m[0][i + 2])))
            {eoe[i], eout[i]} = {1'b1, ahi[i - 6]};
      end
      for (int i = 0; i < 15; i++) begin
         {eoe[i + 11], eout[i + 11]} = {m[1][i], gdat_c[i]};
         c = (i == 7) ? m[3][15:14] : (i > 7 ? m[2][2 * i - 16 +: 2] : m[3][13:12]);
         if (i > 6 && c == 2'h1)
            {eoe[i + 11], eout[i + 11]} = {1'b1, osh[i - 7]};
         if ((i == 11 || i == 12) && c == 2'h2)
            {eoe[i + 11], eout[i + 11]} = {1'b1, dma[i - 11]};
         if (i == 6 && ((c == 2'h1 && md < 2'h2) || c == 2'h3))
            {eoe[i + 11], eout[i + 11]} = {1'b1, c[1] ? strb[0] : cs[2]};
         if (i == 6 && c == 2'h2)
            eoe[i + 11] = 1'b0;
         if (i < 6 && md < 2'h2 && m[3][2 * i])
            {eoe[i + 11], eout[i + 11]} = {i != 2, lo[i]};
      end
      elvl = (eoe & eout) | (~eoe & ((xen & x) | ~xen));
   endtask

   // New random inputs, time for the input filters, then every pin is compared.
   task automatic settle;
      req <= '0;
      {gdat_b, gdir_b, gdat_c, ahi, pwm, osh, dma, cs, strb} <= 63'({$urandom(), $urandom()});
      {x, xen} <= 52'({$urandom(), $urandom()});
      repeat (10) @(posedge clk);
      @(negedge clk);
      model();
      chk("pin_oe", 32'(eoe), 32'({pc_oe, pb_oe}));
      chk("pin_out", 32'(eout & eoe), 32'({pc_out, pb_out} & eoe));
      chk("pin_in", 32'(elvl), 32'({gin_c, gin_b}));
      chk("periph", 32'({m[0][4] & elvl[4], m[0][5] & elvl[5], ~(md < 2'h2 && m[3][4]) | elvl[13],
         m[3][13:12] == 2'h2 && elvl[17]}), 32'({tca, tcb, wt_n, irq}));
      @(posedge clk);
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Reset values, unmapped index, every mode with random fields, then a second reset.
   initial begin
      md = pbcmux_pkg::PBCMUX_MODE_EXP_NOROM;
      {req, x, xen, gdat_b, gdir_b, gdat_c, ahi, pwm, osh, dma, cs, strb} = '0;
      m = '{16'h00c0, 16'h8000, 16'hc000, 16'h0bff};
      void'($urandom(32'h7c17));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 6; a++)
         rd(3'(a));
      wr(3'h5, 16'hffff);
      rd(3'h5);
      settle();
      for (int k = 0; k < 4; k++) begin
         md <= pbcmux_pkg::pbcmux_mode_type'(k);
         for (int j = 0; j < 30; j++) begin
            for (int a = 0; a < 4; a++) begin
               wr(3'(a), 16'($urandom()));
               rd(3'(a));
            end
            settle();
         end
      end
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      m = '{16'h00c0, 16'h8000, 16'hc000, 16'h0bff};
      for (int a = 0; a < 4; a++)
         rd(3'(a));
      settle();
      end_of_test();
   end

   // A hang anywhere ends the run as a failure.
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      end_of_test();
   end
endmodule // test_port_b_c_pin_function_mux
`default_nettype wire
